// ===== inc/opcs_pkg.sv
// constants shared by the overlay pin-control and sync-status logic
//
// Summary of operation
// - sample serial input on serial clock rise
// - update serial output on serial clock fall
// - serial output high impedance while select high
// - flag sync lost after 32 missing lines
// - clear sync lost after 32 valid pulses
// - frame sync low after each vertical interval
// - line sync low after each horizontal interval
// - registers back to defaults by 100us
// - no register access during recovery interval
// - display memory cleared to zero within 20us
// - system clock driven out on clock pin
// - internal mode free-runs frame and line sync
package opcs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int REG_RECOVER_US = 100;
  localparam int REG_RECOVER_CYC = REG_RECOVER_US * CLK_MHZ;
  localparam int MEM_CLEAR_US = 20;
  localparam int MEM_CLEAR_CYC = MEM_CLEAR_US * CLK_MHZ;
  localparam int SYNC_MIN_NS = 2000;
  localparam int SYNC_MIN_CYC = (SYNC_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int BROAD_MIN_NS = 10000;
  localparam int BROAD_MIN_CYC = (BROAD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LINE_NS = 64000;
  localparam int LINE_CYC = LINE_NS * CLK_MHZ / 1000;
  localparam int PULSE_NS = 4700;
  localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
  localparam int LINES_PER_FRAME = 625;
  localparam int LOS_LINES = 32;

  // ****************************************
  // clock output synthesiser
  // ****************************************
  localparam int SYSTEM_CLOCK_OUTPUT_MHZ = 27;
  localparam int NCO_W = 16;
  localparam logic [15:0] NCO_INC = 16'((SYSTEM_CLOCK_OUTPUT_MHZ * (2 ** NCO_W) + CLK_MHZ / 2) / CLK_MHZ);

  // ****************************************
  // serial frame and storage
  // ****************************************
  localparam int FRAME_BITS = 24;
  localparam int CMD_READ_BIT = 23;
  localparam int CMD_MEM_BIT = 22;
  localparam int ADDR_HI_BIT = 16;
  localparam logic [4:0] ADDR_DONE_CNT = 5'h0f;
  localparam logic [4:0] FRAME_LAST_CNT = 5'h17;
  localparam int REG_COUNT = 16;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam int DMEM_DEPTH = 480;
  localparam logic [7:0] DMEM_CLEAR = 8'h00;

endpackage

// ===== verif/opcs_host_model.sv
// host controller model driving the serial port and the reset pin
`timescale 1ns/1ps
module opcs_host_model (
  // clock
  input wire logic clk,
  // host-driven pins
  output logic resetPinN,
  output logic csN,
  output logic sclk,
  output logic serialIn,
  // device-driven pins
  input wire logic serialOut,
  input wire logic serialOutOe
);
  initial begin
    resetPinN = 1'b1;
    csN = 1'b1;
    sclk = 1'b0;
    serialIn = 1'b0;
  end
  // ****************************************
  // serial frames
  // ****************************************
  // half a 64 ns serial clock period, equal halves keep the duty at 50%
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // data is captured late in the high phase: the sampled clock pin makes the device answer slowly
  task automatic xfer(input logic [23:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    csN = 1'b0;
    half();
    for (int i = 0; i < nBits; i++) begin
      serialIn = tx[23-i];
      half();
      sclk = 1'b1;
      half();
      if (i >= 16) begin
        rx = {rx[6:0], serialOutOe ? serialOut : 1'bx};
      end
      sclk = 1'b0;
    end
    half();
    csN = 1'b1;
    // released data line shows the inverse of its last level
    serialIn = ~serialIn;
    half();
    half();
  endtask
  // ****************************************
  // reset pin
  // ****************************************
  // the minimum width is scaled down so the run stays short
  task automatic pulse_reset(input int n);
    resetPinN = 1'b0;
    repeat (n) @(negedge clk);
    resetPinN = 1'b1;
  endtask
endmodule // opcs_host_model

// ===== verif/opcs_top_tb.sv
// self-checking bench for the overlay pin-control and sync-status block
`timescale 1ns/1ps
module opcs_top_tb;
  import opcs_pkg::*;
  // ****************************************
  // clock, wiring and monitors
  // ****************************************
  localparam int RECOV = 400;
  localparam int LLEN = 800;
  logic clk, srst, compSyncN, intSyncMode, resetPinN, csN, sclk, serialIn, serialOut, serialOutOe;
  logic lineSyncOut, lineSyncOe, frameSyncOut, frameSyncOe, syncLostOut, syncLostOe, syncLostFlag;
  logic systemClockOutput, losPin, linePin, framePin, lineQ, frameQ, clkQ;
  logic [7:0] rx;
  int n_fail = 0;
  int n_tests = 0;
  int nLine = 0;
  int nFrame = 0;
  int nClk = 0;
  // open-drain pins sit on pull-ups
  assign losPin = syncLostOe ? syncLostOut : 1'b1;
  assign linePin = lineSyncOe ? lineSyncOut : 1'b1;
  assign framePin = frameSyncOe ? frameSyncOut : 1'b1;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  opcs_top #(.REG_RECOVER(RECOV), .LINE_LEN(LLEN), .FRAME_LINES(5)) i_dut (.clk(clk), .srst(srst),
    .resetPinN(resetPinN), .csN(csN), .sclk(sclk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .compSyncN(compSyncN), .intSyncMode(intSyncMode), .lineSyncOut(lineSyncOut),
    .lineSyncOe(lineSyncOe), .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe), .syncLostOut(syncLostOut),
    .syncLostOe(syncLostOe), .syncLostFlag(syncLostFlag), .systemClockOutput(systemClockOutput));
  opcs_host_model i_host (.clk(clk), .resetPinN(resetPinN), .csN(csN), .sclk(sclk), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutOe(serialOutOe));
  always @(posedge clk) begin
    lineQ <= lineSyncOe;
    frameQ <= frameSyncOe;
    clkQ <= systemClockOutput;
    if (lineSyncOe === 1'b1 && lineQ === 1'b0) nLine <= nLine + 1;
    if (frameSyncOe === 1'b1 && frameQ === 1'b0) nFrame <= nFrame + 1;
    if (systemClockOutput === 1'b1 && clkQ === 1'b0) nClk <= nClk + 1;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic frame(input logic rd, input logic mem, input logic [8:0] addr, input logic [7:0] d, input int nb);
    i_host.xfer({rd, mem, 5'h00, addr, d}, nb, rx);
  endtask
  // sync tip low for w cycles; the pin filter delays what the device sees
  task automatic pulse(input int w);
    compSyncN = 1'b0;
    cycles(w);
    compSyncN = 1'b1;
    cycles(8);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    frame(1'b0, 1'b0, 9'h003, 8'h5a, 24);
    frame(1'b0, 1'b0, 9'h00f, 8'ha5, 24);
    frame(1'b0, 1'b0, 9'h010, 8'h77, 24);
    frame(1'b1, 1'b0, 9'h003, 8'h00, 24);
    check("reg3", 8'h5a, rx);
    frame(1'b1, 1'b0, 9'h00f, 8'h00, 24);
    check("reg15", 8'ha5, rx);
    frame(1'b1, 1'b0, 9'h010, 8'h00, 24);
    check("reg16", 8'h00, rx);
    check("oeIdle", 8'h00, {7'h00, serialOutOe});
    frame(1'b0, 1'b1, 9'h1df, 8'h3c, 24);
    frame(1'b1, 1'b1, 9'h1df, 8'h00, 24);
    check("mem479", 8'h3c, rx);
    frame(1'b1, 1'b1, 9'h1e0, 8'h00, 24);
    check("mem480", 8'h00, rx);
  endtask
  // one bit short: a counter kept across the select rise would complete the write
  task automatic t_partial();
    frame(1'b0, 1'b0, 9'h005, 8'h77, 23);
    frame(1'b1, 1'b0, 9'h005, 8'h00, 24);
    check("partial", 8'h00, rx);
  endtask
  task automatic t_reset();
    i_host.pulse_reset(100);
    cycles(20);
    frame(1'b0, 1'b0, 9'h00e, 8'h11, 24);
    cycles(RECOV + 600);
    frame(1'b1, 1'b0, 9'h003, 8'h00, 24);
    check("reg3Reset", REG_DEFAULT, rx);
    frame(1'b1, 1'b0, 9'h00e, 8'h00, 24);
    check("reg14Recov", REG_DEFAULT, rx);
    frame(1'b1, 1'b1, 9'h1df, 8'h00, 24);
    check("memClear", DMEM_CLEAR, rx);
  endtask
  task automatic t_sync();
    int nf;
    check("losStart", 8'h01, {7'h00, losPin});
    for (int i = 0; i < 32; i++) begin
      pulse(300);
      if (i == 0) check("linePin", 8'h00, {7'h00, linePin});
      if (i == 30) check("los31", 8'h01, {7'h00, losPin});
      if (i == 31) check("los32", 8'h00, {7'h00, losPin});
      if (i == 31) check("flag32", 8'h00, {7'h00, syncLostFlag});
      cycles(392);
    end
    for (int i = 0; i < 3; i++) begin
      pulse(1300);
      cycles(392);
    end
    nf = nFrame;
    pulse(300);
    check("frameSync", 8'h01, 8'(nFrame - nf));
    check("framePin", 8'h00, {7'h00, framePin});
    cycles(392 + 30 * LLEN);
    check("losHeld", 8'h00, {7'h00, losPin});
    cycles(4 * LLEN);
    check("losSet", 8'h01, {7'h00, losPin});
    check("flagSet", 8'h01, {7'h00, syncLostFlag});
  endtask
  task automatic t_int();
    int nl;
    int nf;
    int nc;
    intSyncMode = 1'b1;
    cycles(5 * LLEN + 10);
    nl = nLine;
    nf = nFrame;
    cycles(10 * LLEN);
    check("intLines", 8'h0a, 8'(nLine - nl));
    check("intFrames", 8'h02, 8'(nFrame - nf));
    nc = nClk;
    cycles(1000);
    n_tests++;
    if (nClk - nc < 215 || nClk - nc > 217) begin
      n_fail++;
      $display("ERROR clockOut expected 216 seen %0d", nClk - nc);
    end
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("ERROR timeout expected end of tests seen hang");
    complete_run();
  end
  initial begin
    srst = 1'b1;
    compSyncN = 1'b1;
    intSyncMode = 1'b0;
    cycles(20);
    check("oeReset", 8'h00, {7'h00, serialOutOe});
    check("flagReset", 8'h01, {7'h00, syncLostFlag});
    srst = 1'b0;
    cycles(RECOV + 600);
    t_regs();
    t_partial();
    t_reset();
    t_sync();
    t_int();
    complete_run();
  end
endmodule // opcs_top_tb

// ===== verilog/opcs_sync_in.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module opcs_sync_in #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);
  import opcs_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
      // stage one feeds stage two only; a change counts once two and three agree
      always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= pinIn[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign levelOut[i] = lvl_q;
    end
  endgenerate

endmodule // opcs_sync_in

// ===== verilog/opcs_top.sv
// overlay device pins: serial port, reset recovery, sync outputs, clock out
`timescale 1ns/1ps
module opcs_top #(
  parameter int REG_RECOVER = opcs_pkg::REG_RECOVER_CYC,
  parameter int LINE_LEN = opcs_pkg::LINE_CYC,
  parameter int FRAME_LINES = opcs_pkg::LINES_PER_FRAME
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // reset pin, active low
  input wire logic resetPinN,
  // serial port
  input wire logic csN,
  input wire logic sclk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  // video side
  input wire logic compSyncN,
  input wire logic intSyncMode,
  output logic lineSyncOut,
  output logic lineSyncOe,
  output logic frameSyncOut,
  output logic frameSyncOe,
  output logic syncLostOut,
  output logic syncLostOe,
  output logic syncLostFlag,
  // clock output
  output logic systemClockOutput
);
  import opcs_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pinLvl;
  logic csLvl, sclkLvl, sdiLvl, rstLvl, syncLvl;
  opcs_sync_in #(.WIDTH(5)) u_sync (
    .clk(clk),
    .srst(srst),
    .pinIn({compSyncN, resetPinN, serialIn, sclk, csN}),
    .levelOut(pinLvl)
  );
  assign {syncLvl, rstLvl, sdiLvl, sclkLvl, csLvl} = pinLvl;

  // ****************************************
  // reset recovery
  // ****************************************
  logic [15:0] recovCnt_q, recovCnt_d;
  logic [8:0] clrIdx_q, clrIdx_d;
  logic clrActive_q, clrActive_d, rstPrev_q, regBusy, hold;
  assign hold = srst | ~rstLvl;
  assign regBusy = hold | (recovCnt_q < 16'(REG_RECOVER));
  always_comb begin
    recovCnt_d = recovCnt_q;
    clrIdx_d = clrIdx_q;
    clrActive_d = clrActive_q;
    if (hold) begin
      recovCnt_d = 16'h0000;
      clrIdx_d = 9'h000;
      clrActive_d = 1'b1;
    end else begin
      if (recovCnt_q < 16'(REG_RECOVER)) recovCnt_d = recovCnt_q + 16'h0001;
      // one location per cycle: the sweep ends far inside the memory deadline
      if (clrActive_q) begin
        clrIdx_d = clrIdx_q + 9'h001;
        if (clrIdx_q == 9'(DMEM_DEPTH - 1)) clrActive_d = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    recovCnt_q <= recovCnt_d;
    clrIdx_q <= clrIdx_d;
    clrActive_q <= clrActive_d;
    rstPrev_q <= srst ? 1'b0 : rstLvl;
  end

  // ****************************************
  // serial port
  // ****************************************
  logic sclkPrev_q, csPrev_q, sclkRise, sclkFall, csRise, active;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [23:0] shiftIn_q, shiftIn_d;
  logic [7:0] shiftOut_q, shiftOut_d, rdData;
  logic serialOut_q, serialOut_d, regWe, memWe;
  logic [15:0] hdr;
  logic [8:0] addr;
  logic [7:0] regs [REG_COUNT];
  logic [7:0] dmem [DMEM_DEPTH];
  assign sclkRise = sclkLvl & ~sclkPrev_q;
  assign sclkFall = ~sclkLvl & sclkPrev_q;
  assign csRise = csLvl & ~csPrev_q;
  assign active = ~csLvl & ~regBusy;
  assign hdr = {shiftIn_q[14:0], sdiLvl};
  // at the last bit the register still lacks the final bit, so the address sits one place lower
  assign addr = (bitCnt_q == ADDR_DONE_CNT) ? hdr[8:0] : shiftIn_q[ADDR_HI_BIT - 1 -: 9];
  always_comb begin
    rdData = 8'h00;
    if (hdr[CMD_MEM_BIT - 8]) begin
      if (addr < 9'(DMEM_DEPTH)) rdData = dmem[addr];
    end else if (addr < 9'(REG_COUNT)) begin
      rdData = regs[addr[3:0]];
    end
  end
  always_comb begin
    bitCnt_d = bitCnt_q;
    shiftIn_d = shiftIn_q;
    shiftOut_d = shiftOut_q;
    serialOut_d = serialOut_q;
    regWe = 1'b0;
    memWe = 1'b0;
    if (csLvl) begin
      bitCnt_d = 5'h00;
    end else if (active && sclkRise) begin
      shiftIn_d = {shiftIn_q[22:0], sdiLvl};
      bitCnt_d = bitCnt_q + 5'h01;
      if (bitCnt_q == ADDR_DONE_CNT) shiftOut_d = rdData;
      if (bitCnt_q == FRAME_LAST_CNT) begin
        bitCnt_d = 5'h00;
        regWe = ~shiftIn_q[CMD_READ_BIT - 1] & ~shiftIn_q[CMD_MEM_BIT - 1] & (addr < 9'(REG_COUNT));
        memWe = ~shiftIn_q[CMD_READ_BIT - 1] & shiftIn_q[CMD_MEM_BIT - 1] & (addr < 9'(DMEM_DEPTH));
      end
    end else if (~csLvl && sclkFall) begin
      serialOut_d = shiftOut_q[7];
      if (bitCnt_q > ADDR_DONE_CNT) shiftOut_d = {shiftOut_q[6:0], 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      // matches the synchroniser's reset level so release shows no false edge
      sclkPrev_q <= 1'b1;
      csPrev_q <= 1'b1;
      bitCnt_q <= 5'h00;
      shiftIn_q <= 24'h000000;
      shiftOut_q <= 8'h00;
      serialOut_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkLvl;
      csPrev_q <= csLvl;
      bitCnt_q <= bitCnt_d;
      shiftIn_q <= shiftIn_d;
      shiftOut_q <= shiftOut_d;
      serialOut_q <= serialOut_d;
    end
  end
  assign serialOut = serialOut_q;
  assign serialOutOe = ~csLvl;

  // register bank and display memory; register defaults return while the reset pin is low, the memory clear sweep runs after release
  always_ff @(posedge clk) begin
    for (int r = 0; r < REG_COUNT; r++) begin
      if (hold) regs[r] <= REG_DEFAULT;
      else if (regWe && addr[3:0] == 4'(r)) regs[r] <= {shiftIn_q[6:0], sdiLvl};
    end
    if (clrActive_q) dmem[clrIdx_q] <= DMEM_CLEAR;
    else if (memWe) dmem[addr] <= {shiftIn_q[6:0], sdiLvl};
  end

  // ****************************************
  // sync separator and loss of sync
  // ****************************************
  logic [15:0] width_q, width_d, lineTmr_q, lineTmr_d;
  logic [5:0] missCnt_q, missCnt_d, validCnt_q, validCnt_d;
  logic syncPrev_q, broad_q, broad_d, los_q, los_d, extLine, extFrame, pulseEnd;
  assign pulseEnd = syncLvl & ~syncPrev_q;
  always_comb begin
    width_d = syncLvl ? 16'h0000 : ((width_q == 16'hffff) ? width_q : width_q + 16'h0001);
    lineTmr_d = lineTmr_q + 16'h0001;
    missCnt_d = missCnt_q;
    validCnt_d = validCnt_q;
    broad_d = broad_q;
    los_d = los_q;
    extLine = 1'b0;
    extFrame = 1'b0;
    if (pulseEnd && width_q >= 16'(SYNC_MIN_CYC)) begin
      lineTmr_d = 16'h0000;
      missCnt_d = 6'h00;
      if (validCnt_q < 6'(LOS_LINES)) validCnt_d = validCnt_q + 6'h01;
      if (width_q >= 16'(BROAD_MIN_CYC)) begin
        broad_d = 1'b1;
      end else begin
        extLine = 1'b1;
        extFrame = broad_q; // first narrow pulse after the broad run
        broad_d = 1'b0;
      end
    end else if (lineTmr_q >= 16'(LINE_LEN - 1)) begin
      lineTmr_d = 16'h0000;
      validCnt_d = 6'h00;
      if (missCnt_q < 6'(LOS_LINES)) missCnt_d = missCnt_q + 6'h01;
    end
    if (missCnt_q == 6'(LOS_LINES)) los_d = 1'b1;
    else if (validCnt_q == 6'(LOS_LINES)) los_d = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      width_q <= 16'h0000;
      lineTmr_q <= 16'h0000;
      missCnt_q <= 6'h00;
      validCnt_q <= 6'h00;
      syncPrev_q <= 1'b1;
      broad_q <= 1'b0;
      los_q <= 1'b1;
    end else begin
      width_q <= width_d;
      lineTmr_q <= lineTmr_d;
      missCnt_q <= missCnt_d;
      validCnt_q <= validCnt_d;
      syncPrev_q <= syncLvl;
      broad_q <= broad_d;
      los_q <= los_d;
    end
  end
  assign syncLostFlag = los_q;
  assign syncLostOut = 1'b0;
  assign syncLostOe = ~los_q;

  // ****************************************
  // internal timing and sync outputs
  // ****************************************
  logic [15:0] intTmr_q, intTmr_d;
  logic [9:0] intLine_q, intLine_d;
  logic [15:0] lineLow_q, lineLow_d, frameLow_q, frameLow_d;
  logic intLineTick, intFrameTick, lineTrig, frameTrig;
  assign intLineTick = (intTmr_q >= 16'(LINE_LEN - 1));
  assign intFrameTick = intLineTick && (intLine_q >= 10'(FRAME_LINES - 1));
  assign lineTrig = intSyncMode ? intLineTick : extLine;
  assign frameTrig = intSyncMode ? intFrameTick : extFrame;
  always_comb begin
    intTmr_d = intLineTick ? 16'h0000 : intTmr_q + 16'h0001;
    intLine_d = intFrameTick ? 10'h000 : (intLineTick ? intLine_q + 10'h001 : intLine_q);
    lineLow_d = (lineLow_q != 16'h0000) ? lineLow_q - 16'h0001 : 16'h0000;
    frameLow_d = (frameLow_q != 16'h0000) ? frameLow_q - 16'h0001 : 16'h0000;
    if (lineTrig) lineLow_d = 16'(PULSE_CYC);
    if (frameTrig) frameLow_d = 16'(PULSE_CYC);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      intTmr_q <= 16'h0000;
      intLine_q <= 10'h000;
      lineLow_q <= 16'h0000;
      frameLow_q <= 16'h0000;
    end else begin
      intTmr_q <= intTmr_d;
      intLine_q <= intLine_d;
      lineLow_q <= lineLow_d;
      frameLow_q <= frameLow_d;
    end
  end
  assign lineSyncOut = 1'b0;
  assign lineSyncOe = (lineLow_q != 16'h0000);
  assign frameSyncOut = 1'b0;
  assign frameSyncOe = (frameLow_q != 16'h0000);

  // ****************************************
  // clock output
  // ****************************************
  // phase accumulator: edges carry up to one system period of jitter, a cost of one clock
  logic [15:0] nco_q, nco_d;
  assign nco_d = nco_q + NCO_INC;
  always_ff @(posedge clk) begin
    nco_q <= srst ? 16'h0000 : nco_d;
  end
  assign systemClockOutput = nco_q[15];

  // ****************************************
  // checks
  // ****************************************
  property p_sample;
    @(posedge clk) disable iff (srst) (active && sclkRise && bitCnt_q < 5'h0f) |=> bitCnt_q == $past(bitCnt_q) + 5'h01;
  endproperty
  a_sample: assert property (p_sample) else $error("bit not taken on clock rise");
  property p_fall;
    @(posedge clk) disable iff (srst) (~csLvl && sclkFall && ~(active && sclkRise)) |=> serialOut == $past(shiftOut_q[7]);
  endproperty
  a_fall: assert property (p_fall) else $error("output not updated on clock fall");
  property p_hiz;
    @(posedge clk) disable iff (srst) csLvl |-> !serialOutOe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while deselected");
  property p_losSet;
    @(posedge clk) disable iff (srst) missCnt_q == 6'h20 |=> syncLostFlag ##1 !syncLostOe;
  endproperty
  a_losSet: assert property (p_losSet) else $error("sync loss not flagged");
  property p_losClr;
    @(posedge clk) disable iff (srst) (validCnt_q == 6'h20 && missCnt_q != 6'h20) |=> !syncLostFlag;
  endproperty
  a_losClr: assert property (p_losClr) else $error("sync loss not cleared");
  property p_frame;
    @(posedge clk) disable iff (srst) frameTrig |=> frameSyncOe [*8];
  endproperty
  a_frame: assert property (p_frame) else $error("frame sync not pulled low");
  property p_line;
    @(posedge clk) disable iff (srst) $rose(lineTrig) |=> lineSyncOe [*8];
  endproperty
  a_line: assert property (p_line) else $error("line sync not pulled low");
  property p_noAccess;
    @(posedge clk) disable iff (srst) regBusy |-> !regWe && !memWe && $stable(bitCnt_q) || csLvl;
  endproperty
  a_noAccess: assert property (p_noAccess) else $error("access during recovery");
  property p_clear;
    @(posedge clk) disable iff (srst) (rstLvl && !rstPrev_q) |-> ##[1:490] !clrActive_q;
  endproperty
  a_clear: assert property (p_clear) else $error("memory clear too slow");
  property p_csRise;
    @(posedge clk) disable iff (srst) csRise |=> bitCnt_q == 5'h00;
  endproperty
  a_csRise: assert property (p_csRise) else $error("bit counter not reset");

endmodule // opcs_top
